// ### src/inband_cfg_if.sv
// in-band access settings passed from the register bank to the frame filter
// assumes both ends run on core_clk
`timescale 1ns/100ps
`default_nettype none
interface inband_cfg_if;
   import mgmt_access_pkg::*;
   logic enable;
   logic macMatchEn;
   logic engineReset;
   logic [15:0] etherType;
   portCode_type portSel;
   modport cfg(output enable, macMatchEn, engineReset, etherType, portSel);
   modport filt(input enable, macMatchEn, engineReset, etherType, portSel);
endinterface
`default_nettype wire

// ### src/inband_frame_filter.sv
// filter that picks in-band management frames out of received headers
// assumes header fields arrive on core_clk with a one-cycle valid strobe
`timescale 1ns/100ps
`default_nettype none
`include "mgmt_access_params.svh"
module inband_frame_filter
   import mgmt_access_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   inband_cfg_if.filt cfg,
   input wire logic rxFrameValid,
   input wire logic [47:0] rxDstMac,
   input wire logic [15:0] rxEtherType,
   input wire portCode_type rxPort,
   input wire logic [47:0] switchMac,
   output logic frameAccept_q,
   output logic frameDrop_q,
   output logic macMismatch_q
);
   logic candidate;
   logic macHit;

   // reserved port codes never match, so a misprogrammed field just shuts the path
   assign candidate = rxFrameValid && cfg.enable && (rxEtherType == cfg.etherType)
      && (cfg.portSel <= `INBAND_PORT_LAST) && (rxPort == cfg.portSel);
   assign macHit = !cfg.macMatchEn || (rxDstMac == switchMac);

   always_ff @(posedge core_clk) begin
      if (!rst_n || cfg.engineReset) begin
         frameAccept_q <= 1'b0;
         frameDrop_q <= 1'b0;
         macMismatch_q <= 1'b0;
      end else begin
         frameAccept_q <= candidate && macHit;
         frameDrop_q <= candidate && !macHit;
         macMismatch_q <= candidate && !macHit;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   a_mac_discard: assert property (
      rxFrameValid && cfg.enable && cfg.macMatchEn && !cfg.engineReset && rxDstMac != switchMac
      |=> !frameAccept_q)
      else $error("frame with foreign address accepted");
   a_type_gate: assert property (
      rxFrameValid && rxEtherType != cfg.etherType |=> !frameAccept_q && !frameDrop_q)
      else $error("frame with other ethertype treated as management");
   a_port_gate: assert property (
      rxFrameValid && rxPort != cfg.portSel |=> !frameAccept_q)
      else $error("frame from unselected port accepted");
   a_nomatch_pass: assert property (
      rxFrameValid && cfg.enable && !cfg.macMatchEn && !cfg.engineReset
      && rxEtherType == cfg.etherType && rxPort == cfg.portSel && cfg.portSel <= 3'h2
      |=> frameAccept_q)
      else $error("matching frame not accepted with address check off");
endmodule
`default_nettype wire

// ### src/mgmt_access_config_regs.sv
// serial management and in-band access configuration registers
// assumes the host front ends (spi, mdio, i2c) share core_clk and report busy per transaction
`timescale 1ns/100ps
`default_nettype none
`include "mgmt_access_params.svh"
// Notes on behaviour
// - with preamble suppression clear the mdio port needs a full preamble, with it set frames without one are answered.
// - preamble suppression touches only the mdio port and leaves spi and i2c accesses alone.
// - under automatic edge choice spi read data launch on the rising edge for fast clocks and the falling edge otherwise.
// - automatic edge choice resets to one and while set the manual edge bit is ignored.
// - with automatic choice off the manual bit picks the edge, zero falling and one rising, and it resets to zero.
// - the in-band enable starts from the strap pin sampled at reset and is then writable.
// - with address matching on, in-band frames whose destination differs from the switch address are dropped.
// - writing one to the in-band reset bit restarts the in-band engine and the bit clears itself.
// - in-band responses go to the transmit queue in a two-bit field resetting to 01.
// - a three-bit field picks the management port, codes above 010 are reserved, reset 000.
// - in-band frames are recognised by a writable 16-bit ethertype resetting to 40FE.
// - a received packet with a matching in-band tag clears the done and error flags.
module mgmt_access_config_regs
   import mgmt_access_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic regWrEn,
   input wire logic regRdEn,
   input wire logic [15:0] regAddr,
   input wire logic [3:0] regByteEn,
   input wire logic [31:0] regWrData,
   output logic [31:0] regRdData,
   output logic regRdValid,
   input wire logic inband_enable_strap_pin,
   input wire logic mdioBusy,
   input wire logic spiBusy,
   input wire logic sclRateHigh,
   output logic mdioPreambleSuppress,
   output logic spiLaunchRising,
   output logic inbandEngineReset,
   output logic [1:0] responseQueue,
   input wire logic rxFrameValid,
   input wire logic [47:0] rxDstMac,
   input wire logic [15:0] rxEtherType,
   input wire logic [2:0] rxPort,
   input wire logic [47:0] switchMac,
   output logic frameAccept,
   output logic frameDrop,
   input wire logic tagMatch,
   input wire logic txDoneEvt,
   input wire logic execDoneEvt,
   input wire logic errorEvt,
   output logic [2:0] statusFlags
);
   serCtrl_type serCtrl_q;
   logic inbandEnable_q;
   logic inbandMacMatch_q;
   logic inbandReset_q;
   queue_type inbandQueue_q;
   portCode_type inbandPort_q;
   logic [15:0] inbandEtype_q;
   logic [1:0] strapSync_q;
   logic strapPending_q;
   logic preamble_q;
   logic launchRising_q;
   inbandFlags_type flags_q;
   logic [31:0] rdData_q;
   logic rdValid_q;
   logic macMismatch;
   logic wrSer;
   logic wrInband;
   logic [31:0] inbandWord;
   inband_cfg_if cfgBus();

   assign wrSer = regWrEn && (regAddr == `SER_CTRL_ADDR) && regByteEn[0];
   assign wrInband = regWrEn && (regAddr == `INBAND_CTRL_ADDR);

   // unused groups are left as constant zero in the read word
   assign inbandWord = {inbandEnable_q, inbandMacMatch_q, inbandReset_q, 5'h00, inbandQueue_q, 3'h0, inbandPort_q,
      inbandEtype_q};

   // strap pin is asynchronous to core_clk; only the second stage is read
   always_ff @(posedge core_clk) begin
      strapSync_q <= {strapSync_q[0], inband_enable_strap_pin};
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         serCtrl_q <= {`SER_RESV_RESET, `SER_PREAMBLE_RESET, `SER_AUTO_RESET, `SER_MANUAL_RESET};
      end else if (wrSer) begin
         serCtrl_q <= regWrData[7:0];
      end
   end

   // the strap is caught on the first edge after release, once the synchroniser has settled
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         strapPending_q <= 1'b1;
         inbandEnable_q <= 1'b0;
      end else begin
         strapPending_q <= 1'b0;
         if (wrInband && regByteEn[3]) begin
            inbandEnable_q <= regWrData[`INBAND_ENABLE_BIT];
         end else if (strapPending_q) begin
            inbandEnable_q <= strapSync_q[1];
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         inbandMacMatch_q <= 1'b0;
         inbandReset_q <= 1'b0;
         inbandQueue_q <= `INBAND_QUEUE_RESET;
         inbandPort_q <= `INBAND_PORT_RESET;
         inbandEtype_q <= `INBAND_ETYPE_RESET;
      end else begin
         inbandReset_q <= wrInband && regByteEn[3] && regWrData[`INBAND_RESET_BIT];
         if (wrInband && regByteEn[3]) begin
            inbandMacMatch_q <= regWrData[`INBAND_MACMATCH_BIT];
         end
         if (wrInband && regByteEn[2]) begin
            inbandQueue_q <= regWrData[`INBAND_QUEUE_HI:`INBAND_QUEUE_LO];
            inbandPort_q <= regWrData[`INBAND_PORT_HI:`INBAND_PORT_LO];
         end
         if (wrInband && regByteEn[1]) begin
            inbandEtype_q[15:8] <= regWrData[15:8];
         end
         if (wrInband && regByteEn[0]) begin
            inbandEtype_q[7:0] <= regWrData[7:0];
         end
      end
   end

   // settings are only picked up between transactions so a frame never sees two modes
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         preamble_q <= `SER_PREAMBLE_RESET;
      end else if (!mdioBusy) begin
         preamble_q <= serCtrl_q.preambleSup;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         launchRising_q <= 1'b0;
      end else if (!spiBusy) begin
         launchRising_q <= serCtrl_q.autoEdge ? sclRateHigh : serCtrl_q.manualEdge;
      end
   end

   // a new event in the clearing cycle survives a tag match or an engine reset
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         flags_q <= '0;
      end else begin
         flags_q.txDone <= txDoneEvt || (flags_q.txDone && !tagMatch && !inbandReset_q);
         flags_q.execDone <= execDoneEvt || (flags_q.execDone && !tagMatch && !inbandReset_q);
         flags_q.error <= errorEvt || macMismatch || (flags_q.error && !tagMatch && !inbandReset_q);
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rdData_q <= 32'h0000_0000;
         rdValid_q <= 1'b0;
      end else begin
         rdValid_q <= regRdEn;
         if (!regRdEn) begin
            rdData_q <= 32'h0000_0000;
         end else if (regAddr == `SER_CTRL_ADDR) begin
            rdData_q <= {24'h00_0000, serCtrl_q};
         end else if (regAddr == `INBAND_CTRL_ADDR) begin
            rdData_q <= inbandWord;
         end else begin
            rdData_q <= 32'h0000_0000;
         end
      end
   end

   assign cfgBus.enable = inbandEnable_q;
   assign cfgBus.macMatchEn = inbandMacMatch_q;
   assign cfgBus.engineReset = inbandReset_q;
   assign cfgBus.etherType = inbandEtype_q;
   assign cfgBus.portSel = inbandPort_q;

   inband_frame_filter frameFilter (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .cfg(cfgBus),
      .rxFrameValid(rxFrameValid),
      .rxDstMac(rxDstMac),
      .rxEtherType(rxEtherType),
      .rxPort(rxPort),
      .switchMac(switchMac),
      .frameAccept_q(frameAccept),
      .frameDrop_q(frameDrop),
      .macMismatch_q(macMismatch)
   );

   assign regRdData = rdData_q;
   assign regRdValid = rdValid_q;
   assign mdioPreambleSuppress = preamble_q;
   assign spiLaunchRising = launchRising_q;
   assign inbandEngineReset = inbandReset_q;
   assign responseQueue = inbandQueue_q;
   assign statusFlags = flags_q;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   sequence s_serWrite;
      wrSer ##1 !mdioBusy;
   endsequence
   a_reset_values: assert property ($past(!rst_n) |-> serCtrl_q == 8'h42 && inbandWord[23:0] == 24'h4040FE)
      else $error("register reset value wrong");
   a_preamble_follow: assert property (s_serWrite |=> mdioPreambleSuppress == $past(regWrData[2], 2))
      else $error("preamble setting not applied between frames");
   a_preamble_hold: assert property (mdioBusy |=> $stable(mdioPreambleSuppress))
      else $error("preamble setting changed inside a frame");
   a_auto_edge: assert property (!spiBusy && serCtrl_q.autoEdge |=> spiLaunchRising == $past(sclRateHigh))
      else $error("automatic launch edge wrong");
   a_manual_edge: assert property (!spiBusy && !serCtrl_q.autoEdge |=> spiLaunchRising == $past(serCtrl_q.manualEdge))
      else $error("manual launch edge wrong");
   a_edge_hold: assert property (spiBusy |=> $stable(spiLaunchRising))
      else $error("launch edge changed inside a transaction");
   a_strap_load: assert property (strapPending_q && !wrInband |=> inbandEnable_q == $past(strapSync_q[1]))
      else $error("strap value not loaded");
   a_reset_pulse: assert property (wrInband && regByteEn[3] && regWrData[29] |=> inbandEngineReset
      ##1 (!inbandEngineReset || $past(wrInband && regByteEn[3] && regWrData[29])))
      else $error("in-band reset not a single pulse");
   a_reserved_zero: assert property (regRdValid |-> regRdData[28:24] == 5'h00 && regRdData[21:19] == 3'h0)
      else $error("reserved bits read nonzero");
   a_flag_clear: assert property (tagMatch && !txDoneEvt && !inbandReset_q |=> !statusFlags[2])
      else $error("transmit done not cleared by tag match");
   a_flag_set: assert property (execDoneEvt |=> statusFlags[1])
      else $error("execution done event lost");
endmodule
`default_nettype wire

// ### src/mgmt_access_params.svh
// constants for the management access configuration registers
// assumes byte addresses on the internal register port and a 25 MHz core clock
`ifndef MGMT_ACCESS_PARAMS_SVH
`define MGMT_ACCESS_PARAMS_SVH

`define SER_CTRL_ADDR 16'h0100
`define INBAND_CTRL_ADDR 16'h0104

`define SER_RESV_RESET 5'h08
`define SER_PREAMBLE_RESET 1'b0
`define SER_AUTO_RESET 1'b1
`define SER_MANUAL_RESET 1'b0

`define INBAND_ENABLE_BIT 31
`define INBAND_MACMATCH_BIT 30
`define INBAND_RESET_BIT 29
`define INBAND_QUEUE_HI 23
`define INBAND_QUEUE_LO 22
`define INBAND_PORT_HI 18
`define INBAND_PORT_LO 16
`define INBAND_ETYPE_HI 15
`define INBAND_ETYPE_LO 0

`define INBAND_QUEUE_RESET 2'h1
`define INBAND_PORT_RESET 3'h0
`define INBAND_ETYPE_RESET 16'h40FE
`define INBAND_PORT_LAST 3'h2

`endif

// ### src/mgmt_access_pkg.sv
// types shared by the management access configuration block
// assumes nothing beyond a SystemVerilog compiler
package mgmt_access_pkg;
   typedef logic [2:0] portCode_type;
   typedef logic [1:0] queue_type;
   typedef struct packed {
      logic [4:0] resv;
      logic preambleSup;
      logic autoEdge;
      logic manualEdge;
   } serCtrl_type;
   typedef struct packed {
      logic txDone;
      logic execDone;
      logic error;
   } inbandFlags_type;
endpackage

// ### tb/host_model.sv
// host front-end model: mdio and spi transaction windows plus the measured scl rate
// assumes one-cycle start pulses driven on core_clk
`timescale 1ns/100ps
`default_nettype none
module host_model (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic startMdio,
   input wire logic startSpi,
   input wire logic fastScl,
   output logic mdioBusy,
   output logic spiBusy,
   output logic sclRateHigh
);
   logic [3:0] mdioCnt_q;
   logic [3:0] spiCnt_q;
   // eight busy cycles, long enough for a settings write to land mid-transaction
   always_ff @(posedge core_clk) begin
      if (!rst_n) mdioCnt_q <= 4'h0;
      else if (startMdio) mdioCnt_q <= 4'h8;
      else if (mdioCnt_q != 4'h0) mdioCnt_q <= mdioCnt_q - 4'h1;
   end
   always_ff @(posedge core_clk) begin
      if (!rst_n) spiCnt_q <= 4'h0;
      else if (startSpi) spiCnt_q <= 4'h8;
      else if (spiCnt_q != 4'h0) spiCnt_q <= spiCnt_q - 4'h1;
   end
   assign mdioBusy = (mdioCnt_q != 4'h0);
   assign spiBusy = (spiCnt_q != 4'h0);
   assign sclRateHigh = fastScl;
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// self-checking bench for the management access configuration registers
// assumes the design files and the host model are compiled first
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import mgmt_access_pkg::*;
   logic core_clk = 1'b0;
   logic rst_n, regWrEn, regRdEn, inband_enable_strap_pin, startMdio, startSpi, fastScl;
   logic rxFrameValid, tagMatch, txDoneEvt, execDoneEvt, errorEvt, rxSeen;
   logic regRdValid, mdioBusy, spiBusy, sclRateHigh, mdioPreambleSuppress, spiLaunchRising;
   logic inbandEngineReset, frameAccept, frameDrop;
   logic [15:0] regAddr, rxEtherType, eType;
   logic [3:0] regByteEn;
   logic [31:0] regWrData, regRdData, seed;
   logic [47:0] rxDstMac, switchMac;
   logic [2:0] rxPort, statusFlags;
   logic [1:0] responseQueue;
   logic [31:0] rdExp[$];
   logic [1:0] frExp[$];
   int mismatches = 0;
   int n_compared = 0;
   always #20 core_clk = ~core_clk;
   mgmt_access_config_regs i_dut (.core_clk, .rst_n, .regWrEn, .regRdEn, .regAddr, .regByteEn,
      .regWrData, .regRdData, .regRdValid, .inband_enable_strap_pin, .mdioBusy, .spiBusy,
      .sclRateHigh, .mdioPreambleSuppress, .spiLaunchRising, .inbandEngineReset, .responseQueue,
      .rxFrameValid, .rxDstMac, .rxEtherType, .rxPort, .switchMac, .frameAccept, .frameDrop,
      .tagMatch, .txDoneEvt, .execDoneEvt, .errorEvt, .statusFlags);
   host_model i_host (.core_clk, .rst_n, .startMdio, .startSpi, .fastScl, .mdioBusy, .spiBusy,
      .sclRateHigh);
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n = 1);
      repeat (n) @(posedge core_clk);
      #2;
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] be);
      regAddr = a;
      regWrData = d;
      regByteEn = be;
      regWrEn = 1'b1;
      tick();
      regWrEn = 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [31:0] e);
      regAddr = a;
      rdExp.push_back(e);
      regRdEn = 1'b1;
      tick();
      regRdEn = 1'b0;
   endtask
   task automatic frame(input logic [47:0] m, input logic [15:0] t, input logic [2:0] p,
      input logic [1:0] e);
      rxDstMac = m;
      rxEtherType = t;
      rxPort = p;
      frExp.push_back(e);
      rxFrameValid = 1'b1;
      tick();
      rxFrameValid = 1'b0;
   endtask
   task automatic stop_test();
      if (rdExp.size() != 0 || frExp.size() != 0) begin
         mismatches++;
         $display("[FAIL] %0t expected results never appeared", $time);
      end
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // results are compared mid-cycle while they stand, against notes queued by the drivers
   always @(negedge core_clk) begin
      if (regRdValid === 1'b1) check(regRdData, rdExp.pop_front());
      if (rxSeen === 1'b1) check(32'({frameAccept, frameDrop}), 32'(frExp.pop_front()));
      rxSeen <= rxFrameValid;
   end
   initial begin
      #100000;
      mismatches++;
      stop_test();
   end
   initial begin
      {rst_n, regWrEn, regRdEn, startMdio, startSpi, fastScl, rxFrameValid, rxSeen} = 8'h00;
      {tagMatch, txDoneEvt, execDoneEvt, errorEvt} = 4'h0;
      {regAddr, regByteEn, regWrData, rxDstMac, rxEtherType, rxPort} = '0;
      inband_enable_strap_pin = 1'b1;
      switchMac = 48'h0A1B2C3D4E5F;
      seed = 32'h0000052C;
      tick(5);
      rst_n = 1'b1;
      tick();
      rd(16'h0100, 32'h00000042);
      tick();
      rd(16'h0104, 32'h804040FE);
      check(32'(responseQueue), 32'h1);
      for (int i = 0; i < 8; i++) begin
         fastScl = i[2];
         wr(16'h0100, {24'h0, 5'h08, 1'b0, i[1], i[0]}, 4'h1);
         tick(2);
         check(32'(spiLaunchRising), 32'(i[1] ? i[2] : i[0]));
      end
      wr(16'h0100, 32'h47, 4'h1);
      tick();
      wr(16'h0100, 32'hFF, 4'hE);
      rd(16'h0100, 32'h47);
      tick(2);
      check(32'(mdioPreambleSuppress), 32'h1);
      startSpi = 1'b1;
      tick();
      startSpi = 1'b0;
      wr(16'h0100, 32'h40, 4'h1);
      tick(2);
      check(32'(spiLaunchRising), 32'h1);
      check(32'(mdioPreambleSuppress), 32'h0);
      tick(8);
      check(32'(spiLaunchRising), 32'h0);
      startMdio = 1'b1;
      tick();
      startMdio = 1'b0;
      wr(16'h0100, 32'h44, 4'h1);
      tick(2);
      check(32'(mdioPreambleSuppress), 32'h0);
      tick(8);
      check(32'(mdioPreambleSuppress), 32'h1);
      seed = xorshift(seed);
      eType = seed[15:0];
      wr(16'h0104, {3'b110, 5'h1F, 2'h2, 3'h7, 3'h1, eType}, 4'hF);
      rd(16'h0104, {3'b110, 5'h00, 2'h2, 3'h0, 3'h1, eType});
      check(32'(responseQueue), 32'h2);
      frame(switchMac, eType, 3'h1, 2'b10);
      tick();
      frame(switchMac ^ 48'h1, eType, 3'h1, 2'b01);
      tick();
      frame(switchMac, eType ^ 16'h1, 3'h1, 2'b00);
      tick();
      frame(switchMac, eType, 3'h2, 2'b00);
      wr(16'h0104, {3'b100, 5'h00, 2'h2, 3'h0, 3'h1, eType}, 4'hF);
      frame(switchMac ^ 48'h1, eType, 3'h1, 2'b10);
      {txDoneEvt, execDoneEvt} = 2'b11;
      tick();
      {txDoneEvt, execDoneEvt} = 2'b00;
      tick();
      check(32'(statusFlags), 32'h7);
      tagMatch = 1'b1;
      tick();
      tagMatch = 1'b0;
      tick();
      check(32'(statusFlags), 32'h0);
      wr(16'h0104, {3'b101, 5'h00, 2'h2, 3'h0, 3'h1, eType}, 4'h8);
      check(32'(inbandEngineReset), 32'h1);
      tick();
      check(32'(inbandEngineReset), 32'h0);
      rd(16'h0104, {3'b100, 5'h00, 2'h2, 3'h0, 3'h1, eType});
      inband_enable_strap_pin = 1'b0;
      rst_n = 1'b0;
      tick(5);
      rst_n = 1'b1;
      tick();
      rd(16'h0104, 32'h004040FE);
      tick();
      rd(16'h0108, 32'h0);
      tick(3);
      stop_test();
   end
endmodule
`default_nettype wire
